// [hdl/osp_seq.sv]
// output sequencing, ramping and protection manager of a step-down converter
// assumes monitor readings and the sync line are synchronous to clk
`timescale 1ns/10ps

// Overview of operation
// - setpoint code maps to 0.5-5.5 V in 12.5, 25, 50 mV sub-ranges.
// - turn-on delay runs from turn-on command to start of upward ramp.
// - with falling slew, shutdown delay ends when output reaches zero.
// - pre-ramp wait is shutdown delay minus ramp-down time; manager clamps it at zero.
// - without falling slew, shutdown delay ends by opening both switches.
// - ramps move the reference one 12.5 mV step per dwell.
// - dwell is counted in master clock edges from the sync line.
// - droop from current limit register lowers reference as load rises.
// - uv and power-good levels are percentages of active setpoint, recomputed live.
// - non-latching fault retries start-up every 130 ms with normal sequencing.
// - latching fault stays off; restart after 130 ms on clear or cycled command.
// - warnings never turn the output off, only flag and report.
// - above 120 C temperature flag goes 0 and is reported if enabled.
// - below 117 C temperature flag returns to 1.
// - power-ok pin pulled low outside 110 % and 90/95 % window.
// - power-ok judged only in steady state, held low during transitions.
// - power-good flag goes 0 and reported; back in window releases pin and flag.
// - external low on power-ok pin raises the power-good warning.
// - overcurrent, overtemperature, undervoltage or tracking fault turns output off.
// - armed overcurrent below uv level clears its flag and opens switches at once.
// - overcurrent threshold gets temperature compensation unless disabled.
// - sync line carries master clock; data transfer handled outside this block.
module osp_seq #(
	parameter int DLY_LSB_CYC_P = osp_pkg::DLY_LSB_CYC,
	parameter int RETRY_CYC_P   = osp_pkg::RETRY_CYC,
	parameter int SYNC_CYC_P    = osp_pkg::SYNC_CYC
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire osp_pkg::osp_bus_t bus,
	output logic [7:0]            rdata,
	input  wire osp_pkg::osp_mon_t mon,
	input  wire logic             sync_data_line_i,
	input  wire logic             power_ok_pin_i,
	output logic                  power_ok_pin_o,
	output logic                  power_ok_pin_oe,
	output logic                  sw_en,
	output logic [8:0]            ref_out,
	output logic [8:0]            vref_out,
	output logic                  warn_notify
);
	osp_pkg::osp_state_t st_r;
	logic [7:0]  fault_type_config_r;
	logic [7:0]  threshold_config_r;
	logic [7:0]  reporting_config_r;
	logic [7:0]  rise_rate_r;
	logic [7:0]  fall_rate_r;
	logic [7:0]  turn_on_delay_r;
	logic [7:0]  shutdown_delay_r;
	logic [7:0]  setpoint_r;
	logic [7:0]  current_limit_setpoint_r;
	logic        run_r;
	logic [5:0]  fault_flag_word_r;
	logic [31:0] tmr_r;
	logic [8:0]  ref_r;
	logic [9:0]  pb_r;
	logic        oc_arm_r;
	logic        pend_r;
	logic        lat_r;
	logic [3:0]  hitv_r;
	logic        run_cyc_r;
	logic        tw_r;
	logic        sd_d_r;
	logic [7:0]  dcnt_r;
	logic [9:0]  pg_hi_r;
	logic [9:0]  pg_lo_r;
	logic [9:0]  uv_r;
	logic        pg_low_r;

	function automatic logic [8:0] sp_ref(input logic [7:0] c);
		if (c <= osp_pkg::SR1_MAX_C)
			return osp_pkg::SR1_BASE_C + {1'b0, c};
		else if (c <= osp_pkg::SR2_MAX_C)
			return osp_pkg::SR2_BASE_C + {c - osp_pkg::SR1_MAX_C, 1'b0};
		else
			return osp_pkg::SR3_BASE_C + 9'({c - osp_pkg::SR2_MAX_C, 2'b00});
	endfunction

	function automatic logic [9:0] pct(input logic [8:0] r, input int p);
		return 10'((int'(r) * p) / 100);
	endfunction

	// ramp-down time is budgeted from the nominal master clock period
	function automatic logic [31:0] pre_wait(input logic [7:0] shutdown_delay, input logic [8:0] r,
			input logic [7:0] fr);
		int t;
		t = int'(shutdown_delay) * DLY_LSB_CYC_P - int'(r) * int'(fr) * SYNC_CYC_P;
		return (t > 0) ? 32'(t) : 32'h0;
	endfunction

	logic [8:0] tgt;
	logic       on;
	logic       sd_edge;
	logic [7:0] dwell;
	logic       tick;
	logic [7:0] tcomp;
	logic [8:0] oc_thr;
	logic [9:0] vdiff;
	logic       oc_hit;
	logic       tr_hit;
	logic       uv_hit;
	logic       ot_hit;
	logic       fast;
	logic       slow;
	logic       own_bad;
	logic       cleared;
	logic [8:0] droop;

	always_comb begin
		tgt     = sp_ref(setpoint_r);
		on      = (st_r == osp_pkg::S_RAMP) || (st_r == osp_pkg::S_STDY) ||
		          (st_r == osp_pkg::S_OFFW) || (st_r == osp_pkg::S_RDN);
		sd_edge = sync_data_line_i && !sd_d_r;
		dwell   = (st_r == osp_pkg::S_RDN) ? fall_rate_r : rise_rate_r;
		if (dwell == 8'h00)
			dwell = 8'h01;
		tick    = sd_edge && (dcnt_r + 8'h01 >= dwell);
		tcomp   = 8'h00;
		if (!current_limit_setpoint_r[osp_pkg::CL_TC_DIS] && mon.temp > osp_pkg::ROOM_C)
			tcomp = (mon.temp - osp_pkg::ROOM_C) >> 2;
		oc_thr  = 9'({1'b0, current_limit_setpoint_r[6:4]} + 4'h1) * osp_pkg::OC_STEP_C + 9'(tcomp);
		vdiff   = (mon.vout > {1'b0, ref_r}) ? mon.vout - {1'b0, ref_r} : {1'b0, ref_r} - mon.vout;
		oc_hit  = on && oc_arm_r && {1'b0, mon.iout} >= oc_thr && mon.vout < uv_r;
		tr_hit  = (st_r == osp_pkg::S_RAMP) && (ref_r < tgt) && !pend_r &&
		          !fault_type_config_r[osp_pkg::FT_TR_DIS] && vdiff > 10'(osp_pkg::TRACK_STEPS);
		uv_hit  = (st_r == osp_pkg::S_STDY) && mon.vout < uv_r && !oc_hit;
		ot_hit  = on && mon.temp > osp_pkg::OT_TRIP_C;
		fast    = oc_hit || tr_hit;
		slow    = uv_hit || ot_hit;
		// power-good is judged only in steady state
		own_bad = (st_r != osp_pkg::S_STDY) || mon.vout > pg_hi_r || mon.vout < pg_lo_r;
		cleared = &(fault_flag_word_r[5:2] | ~hitv_r);
		droop   = 9'(({4'h0, mon.iout} * {8'h00, current_limit_setpoint_r[3:0]}) >> 4);
	end

	// software registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_type_config_r      <= osp_pkg::R_FTYPE;
			threshold_config_r       <= osp_pkg::R_THR;
			reporting_config_r       <= osp_pkg::R_REP;
			rise_rate_r              <= osp_pkg::R_RISE;
			fall_rate_r              <= osp_pkg::R_FALL;
			turn_on_delay_r          <= osp_pkg::R_TON;
			shutdown_delay_r         <= osp_pkg::R_TOFF;
			setpoint_r               <= osp_pkg::R_SP;
			current_limit_setpoint_r <= osp_pkg::R_CLS;
			run_r                    <= 1'b0;
		end else if (bus.wr) begin
			unique case (bus.addr)
				osp_pkg::A_FTYPE: fault_type_config_r <= bus.wdata;
				osp_pkg::A_THR:   threshold_config_r <= bus.wdata;
				osp_pkg::A_REP:   reporting_config_r <= bus.wdata;
				osp_pkg::A_RISE:  rise_rate_r <= bus.wdata;
				osp_pkg::A_FALL:  fall_rate_r <= bus.wdata;
				osp_pkg::A_TON:   turn_on_delay_r <= bus.wdata;
				osp_pkg::A_TOFF:  shutdown_delay_r <= bus.wdata;
				osp_pkg::A_SP:    setpoint_r <= bus.wdata;
				osp_pkg::A_CLS:   current_limit_setpoint_r <= bus.wdata;
				osp_pkg::A_RUN:   run_r <= bus.wdata[0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (bus.rd) begin
			unique case (bus.addr)
				osp_pkg::A_FTYPE: rdata <= fault_type_config_r;
				osp_pkg::A_THR:   rdata <= threshold_config_r;
				osp_pkg::A_REP:   rdata <= reporting_config_r;
				osp_pkg::A_RISE:  rdata <= rise_rate_r;
				osp_pkg::A_FALL:  rdata <= fall_rate_r;
				osp_pkg::A_TON:   rdata <= turn_on_delay_r;
				osp_pkg::A_TOFF:  rdata <= shutdown_delay_r;
				osp_pkg::A_SP:    rdata <= setpoint_r;
				osp_pkg::A_CLS:   rdata <= current_limit_setpoint_r;
				osp_pkg::A_RUN:   rdata <= {7'h00, run_r};
				osp_pkg::A_STAT:  rdata <= {2'b00, fault_flag_word_r};
				osp_pkg::A_REF:   rdata <= ref_r[8:1];
				osp_pkg::A_STATE: rdata <= {1'b0, st_r};
				default:          rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

	// status word: hardware event beats a software write of one
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			fault_flag_word_r <= osp_pkg::R_STAT;
		else begin
			fault_flag_word_r[osp_pkg::ST_PT] <= !tw_r;
			fault_flag_word_r[osp_pkg::ST_PG] <= !pg_low_r;
			for (int i = osp_pkg::ST_OC; i <= osp_pkg::ST_TR; i++) begin
				if ((i == osp_pkg::ST_OC && oc_hit) || (i == osp_pkg::ST_UV && uv_hit) ||
				    (i == osp_pkg::ST_OT && ot_hit) || (i == osp_pkg::ST_TR && tr_hit))
					fault_flag_word_r[i] <= 1'b0;
				else if (bus.wr && bus.addr == osp_pkg::A_STAT && bus.wdata[i])
					fault_flag_word_r[i] <= 1'b1;
			end
		end
	end

	// warnings: hysteresis on temperature, live power-good window
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tw_r     <= 1'b0;
			pg_low_r <= 1'b1;
			pg_hi_r  <= 10'h000;
			pg_lo_r  <= 10'h000;
			uv_r     <= 10'h000;
		end else begin
			if (mon.temp > osp_pkg::TW_SET_C)
				tw_r <= 1'b1;
			else if (mon.temp < osp_pkg::TW_CLR_C)
				tw_r <= 1'b0;
			pg_low_r <= own_bad || !power_ok_pin_i;
			pg_hi_r  <= pct(tgt, osp_pkg::PG_HI_PCT);
			pg_lo_r  <= pct(tgt, threshold_config_r[osp_pkg::TH_PG95] ? osp_pkg::PG_LO_B_PCT
			                                                          : osp_pkg::PG_LO_A_PCT);
			unique case (threshold_config_r[1:0])
				2'h0: uv_r <= pct(tgt, osp_pkg::UV_PCT_0);
				2'h1: uv_r <= pct(tgt, osp_pkg::UV_PCT_1);
				2'h2: uv_r <= pct(tgt, osp_pkg::UV_PCT_2);
				2'h3: uv_r <= pct(tgt, osp_pkg::UV_PCT_3);
			endcase
		end
	end

	// pins and notifications; the pin is never driven high, pull-up releases it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_ok_pin_o  <= 1'b0;
			power_ok_pin_oe <= 1'b1;
			warn_notify     <= 1'b0;
			vref_out        <= 9'h000;
		end else begin
			power_ok_pin_o  <= 1'b0;
			power_ok_pin_oe <= own_bad;
			warn_notify     <= (reporting_config_r[osp_pkg::RP_TW] && tw_r) ||
			                   (reporting_config_r[osp_pkg::RP_PG] && pg_low_r);
			vref_out        <= (droop > ref_r) ? 9'h000 : ref_r - droop;
		end
	end

	// master clock edge divider sets the dwell of each step
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sd_d_r <= 1'b0;
			dcnt_r <= 8'h00;
		end else begin
			sd_d_r <= sync_data_line_i;
			if (st_r != osp_pkg::S_RAMP && st_r != osp_pkg::S_RDN)
				dcnt_r <= 8'h00;
			else if (tick)
				dcnt_r <= 8'h00;
			else if (sd_edge)
				dcnt_r <= dcnt_r + 8'h01;
		end
	end

	// sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r      <= osp_pkg::S_OFF;
			tmr_r     <= 32'h0;
			ref_r     <= 9'h000;
			sw_en     <= 1'b0;
			pb_r      <= 10'h000;
			oc_arm_r  <= 1'b0;
			pend_r    <= 1'b0;
			lat_r     <= 1'b0;
			hitv_r    <= 4'h0;
			run_cyc_r <= 1'b0;
		end else begin
			if (tmr_r != 32'h0)
				tmr_r <= tmr_r - 32'h1;
			if (on && mon.vout > pb_r)
				oc_arm_r <= 1'b1;
			if (fast || slow) begin
				hitv_r <= {tr_hit, ot_hit, uv_hit, oc_hit};
				lat_r  <= |({tr_hit, ot_hit, uv_hit, oc_hit} & fault_type_config_r[3:0]);
			end
			if (fast) begin
				// fast turn-off: both switches open this edge
				st_r     <= osp_pkg::S_HOLD;
				sw_en    <= 1'b0;
				ref_r    <= 9'h000;
				oc_arm_r <= 1'b0;
				tmr_r    <= 32'(RETRY_CYC_P);
				run_cyc_r <= 1'b0;
			end else begin
				if (slow)
					pend_r <= 1'b1;
				unique case (st_r)
					osp_pkg::S_OFF: begin
						pend_r   <= 1'b0;
						oc_arm_r <= 1'b0;
						if (run_r) begin
							st_r  <= osp_pkg::S_ONW;
							tmr_r <= 32'(int'(turn_on_delay_r) * DLY_LSB_CYC_P);
						end
					end
					osp_pkg::S_ONW: begin
						if (!run_r)
							st_r <= osp_pkg::S_OFF;
						else if (tmr_r == 32'h0) begin
							st_r  <= osp_pkg::S_RAMP;
							sw_en <= 1'b1;
							pb_r  <= mon.vout;
						end
					end
					osp_pkg::S_RAMP, osp_pkg::S_STDY: begin
						if (!run_r || slow) begin
							st_r  <= osp_pkg::S_OFFW;
							tmr_r <= (fall_rate_r == 8'h00)
							         ? 32'(int'(shutdown_delay_r) * DLY_LSB_CYC_P)
							         : pre_wait(shutdown_delay_r, ref_r, fall_rate_r);
						end else if (ref_r == tgt)
							st_r <= osp_pkg::S_STDY;
						else begin
							st_r <= osp_pkg::S_RAMP;
							if (tick)
								ref_r <= (ref_r < tgt) ? ref_r + 9'h001 : ref_r - 9'h001;
						end
					end
					osp_pkg::S_OFFW: begin
						if (tmr_r == 32'h0) begin
							if (fall_rate_r != 8'h00)
								st_r <= osp_pkg::S_RDN;
							else begin
								sw_en <= 1'b0;
								ref_r <= 9'h000;
								st_r  <= (pend_r || slow) ? osp_pkg::S_HOLD : osp_pkg::S_OFF;
								tmr_r <= 32'(RETRY_CYC_P);
								run_cyc_r <= 1'b0;
							end
						end
					end
					osp_pkg::S_RDN: begin
						if (ref_r == 9'h000) begin
							sw_en <= 1'b0;
							st_r  <= (pend_r || slow) ? osp_pkg::S_HOLD : osp_pkg::S_OFF;
							tmr_r <= 32'(RETRY_CYC_P);
							run_cyc_r <= 1'b0;
						end else if (tick)
							ref_r <= ref_r - 9'h001;
					end
					osp_pkg::S_HOLD: begin
						pend_r <= 1'b0;
						if (!run_r)
							run_cyc_r <= 1'b1;
						if (tmr_r == 32'h0) begin
							if (!run_r)
								st_r <= osp_pkg::S_OFF;
							else if (!lat_r ||
							         (mon.temp <= osp_pkg::OT_TRIP_C && (cleared || run_cyc_r))) begin
								st_r  <= osp_pkg::S_ONW;
								tmr_r <= 32'(int'(turn_on_delay_r) * DLY_LSB_CYC_P);
							end
						end
					end
				endcase
			end
		end
	end

	always_comb ref_out = ref_r;

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_ton;
		st_r == osp_pkg::S_ONW && tmr_r == 32'h0 && run_r && !fast |=> st_r == osp_pkg::S_RAMP && sw_en;
	endproperty
	a_ton: assert property (p_ton) else $error("turn-on delay end did not start the ramp");

	property p_step;
		st_r == osp_pkg::S_RAMP && !fast |=> (ref_r - $past(ref_r) == 9'h001) ||
		    ($past(ref_r) - ref_r == 9'h001) || ref_r == $past(ref_r) || st_r == osp_pkg::S_HOLD;
	endproperty
	a_step: assert property (p_step) else $error("ramp moved more than one step");

	property p_pok;
		st_r != osp_pkg::S_STDY |=> power_ok_pin_oe;
	endproperty
	a_pok: assert property (p_pok) else $error("power-ok released outside steady state");

	property p_oc;
		oc_hit |=> !sw_en && !fault_flag_word_r[osp_pkg::ST_OC] ##1 st_r == osp_pkg::S_HOLD;
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent did not open switches");

	property p_tw;
		mon.temp > osp_pkg::TW_SET_C |=> ##1 !fault_flag_word_r[osp_pkg::ST_PT];
	endproperty
	a_tw: assert property (p_tw) else $error("temperature flag not set above limit");

	property p_twc;
		mon.temp < osp_pkg::TW_CLR_C |=> ##1 fault_flag_word_r[osp_pkg::ST_PT];
	endproperty
	a_twc: assert property (p_twc) else $error("temperature flag not cleared below limit");

	property p_retry;
		st_r == osp_pkg::S_HOLD && tmr_r == 32'h0 && run_r && !lat_r |=> st_r == osp_pkg::S_ONW;
	endproperty
	a_retry: assert property (p_retry) else $error("non-latching retry missed");

	property p_dn;
		st_r == osp_pkg::S_RDN && ref_r == 9'h000 && !fast |=> !sw_en &&
		    (st_r == osp_pkg::S_OFF || st_r == osp_pkg::S_HOLD);
	endproperty
	a_dn: assert property (p_dn) else $error("ramp-down did not end at zero");

	property p_warn;
		st_r == osp_pkg::S_STDY && run_r && !fast && !slow |=> sw_en;
	endproperty
	a_warn: assert property (p_warn) else $error("output lost without a fault");

	property p_nsl;
		st_r == osp_pkg::S_OFFW && tmr_r == 32'h0 && fall_rate_r == 8'h00 && !fast |=> !sw_en;
	endproperty
	a_nsl: assert property (p_nsl) else $error("switches left on after shutdown delay");
endmodule

// [common/osp_pkg.sv]
// shared constants, register map and carrier types of the output sequencing block
// assumes a 50 MHz system clock; voltages are in 12.5 mV reference steps, except TRACK_MV in mV
package osp_pkg;
	localparam int CLK_HZ      = 50_000_000;
	// turn-on and shutdown delay registers count in this unit
	localparam int DLY_LSB_US  = 1000;
	localparam int DLY_LSB_CYC = CLK_HZ / 1_000_000 * DLY_LSB_US;
	localparam int RETRY_MS    = 130;
	localparam int RETRY_CYC   = CLK_HZ / 1000 * RETRY_MS;
	// nominal master clock on the sync line, used to size the pre-ramp wait
	localparam int SYNC_HZ     = 1_000_000;
	localparam int SYNC_CYC    = CLK_HZ / SYNC_HZ;
	localparam int TRACK_MV    = 250;
	localparam int TRACK_STEPS = TRACK_MV * 10 / 125;
	localparam int PG_HI_PCT   = 110;
	localparam int PG_LO_A_PCT = 90;
	localparam int PG_LO_B_PCT = 95;
	localparam int UV_PCT_0    = 75;
	localparam int UV_PCT_1    = 80;
	localparam int UV_PCT_2    = 85;
	localparam int UV_PCT_3    = 90;

	localparam logic [7:0] TW_SET_C  = 8'h78;
	localparam logic [7:0] TW_CLR_C  = 8'h75;
	localparam logic [7:0] OT_TRIP_C = 8'h78;
	localparam logic [7:0] ROOM_C    = 8'h19;
	localparam logic [7:0] OC_STEP_C = 8'h10;

	// setpoint code sub-ranges: 12.5 mV, 25 mV, 50 mV per code
	localparam logic [7:0] SR1_MAX_C  = 8'h78;
	localparam logic [7:0] SR2_MAX_C  = 8'hfa;
	localparam logic [8:0] SR1_BASE_C = 9'h028;
	localparam logic [8:0] SR2_BASE_C = 9'h0a0;
	localparam logic [8:0] SR3_BASE_C = 9'h1a4;

	localparam logic [3:0] A_FTYPE = 4'h0;
	localparam logic [3:0] A_THR   = 4'h1;
	localparam logic [3:0] A_REP   = 4'h2;
	localparam logic [3:0] A_RISE  = 4'h3;
	localparam logic [3:0] A_FALL  = 4'h4;
	localparam logic [3:0] A_TON   = 4'h5;
	localparam logic [3:0] A_TOFF  = 4'h6;
	localparam logic [3:0] A_SP    = 4'h7;
	localparam logic [3:0] A_CLS   = 4'h8;
	localparam logic [3:0] A_RUN   = 4'h9;
	localparam logic [3:0] A_STAT  = 4'ha;
	localparam logic [3:0] A_REF   = 4'hb;
	localparam logic [3:0] A_STATE = 4'hc;

	localparam logic [7:0] R_FTYPE = 8'h00;
	localparam logic [7:0] R_THR   = 8'h02;
	localparam logic [7:0] R_REP   = 8'h03;
	localparam logic [7:0] R_RISE  = 8'h0a;
	localparam logic [7:0] R_FALL  = 8'h0a;
	localparam logic [7:0] R_TON   = 8'h01;
	localparam logic [7:0] R_TOFF  = 8'h0a;
	localparam logic [7:0] R_SP    = 8'h28;
	localparam logic [7:0] R_CLS   = 8'h30;
	localparam logic [5:0] R_STAT  = 6'h3f;

	// status bits, 0 means the event is present
	localparam int ST_PT = 0;
	localparam int ST_PG = 1;
	localparam int ST_OC = 2;
	localparam int ST_UV = 3;
	localparam int ST_OT = 4;
	localparam int ST_TR = 5;
	// fault_type_config: bits 0..3 latch oc, uv, ot, tr; bit 4 disables tracking
	localparam int FT_TR_DIS = 4;
	// threshold_config: bits 1:0 uv select, bit 2 power-good low at 95 %
	localparam int TH_PG95 = 2;
	// current_limit_setpoint: 3:0 droop slope, 6:4 oc level, 7 comp disable
	localparam int CL_TC_DIS = 7;
	localparam int RP_TW = 0;
	localparam int RP_PG = 1;

	typedef enum logic [6:0] {
		S_OFF   = 7'h01,
		S_ONW   = 7'h02,
		S_RAMP  = 7'h04,
		S_STDY  = 7'h08,
		S_OFFW  = 7'h10,
		S_RDN   = 7'h20,
		S_HOLD  = 7'h40
	} osp_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} osp_bus_t;

	typedef struct packed {
		logic [9:0] vout;
		logic [7:0] iout;
		logic [7:0] temp;
	} osp_mon_t;
endpackage

// [dv/osp_mgr_model.sv]
// power manager model on the far side of the sync line
// assumes the block's clk; the master clock runs free, as a master clock does
`timescale 1ns/10ps
module osp_mgr_model #(
	parameter int DIV = 1
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      sync_data_line
);
	int cnt;

	// one master clock shared by every module, so all ramps stay in step
	// data transfer is not modelled; no margining is ever issued
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			sync_data_line <= 1'b0;
		end else if (cnt == DIV - 1) begin
			cnt <= 0;
			sync_data_line <= ~sync_data_line;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// [dv/osp_seq_tb.sv]
// self-checking bench of osp_seq with a load model and an integer model
// assumes shortened delay, retry and master clock counts
`timescale 1ns/10ps
module osp_seq_tb;
	localparam int DLY = 4;
	localparam int RETRY = 50;
	localparam logic [7:0] STDY = 8'(osp_pkg::S_STDY);
	logic              clk, rst, sync_ln, pok_o, pok_oe, sw_en, warn, ext_low, follow, step_on;
	osp_pkg::osp_bus_t bus;
	osp_pkg::osp_mon_t mon;
	logic [7:0]        rdata, rv;
	logic [8:0]        ref_out, vref_out, prev_ref;
	logic [31:0]       seed;
	int                n_errors, n_tests, n, k;
	int                codes[6] = '{120, 121, 250, 251, 255, 40};
	// open-drain pin with pull-up, pulled low by the block or by the bench
	wire               pok_pin = (pok_oe ? pok_o : 1'b1) & ~ext_low;

	osp_seq #(.DLY_LSB_CYC_P(DLY), .RETRY_CYC_P(RETRY), .SYNC_CYC_P(2)) dut (
		.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .mon(mon), .sync_data_line_i(sync_ln),
		.power_ok_pin_i(pok_pin), .power_ok_pin_o(pok_o), .power_ok_pin_oe(pok_oe),
		.sw_en(sw_en), .ref_out(ref_out), .vref_out(vref_out), .warn_notify(warn));
	osp_mgr_model #(.DIV(1)) mgr (.clk(clk), .rst(rst), .sync_data_line(sync_ln));

	function automatic int sp_steps(input int c);
		if (c <= 120)
			return 40 + c;
		if (c <= 250)
			return 160 + 2 * (c - 120);
		return 420 + 4 * (c - 250);
	endfunction

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d of %0d checks", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask

	task automatic stat(input int b, input logic exp);
		rd(osp_pkg::A_STAT, rv);
		check(16'(rv[b]), 16'(exp));
	endtask

	// a hang in any wait closes the run as a mismatch
	task automatic wait_sw(input logic v, input int lim, output int c);
		for (c = 0; c < lim && sw_en !== v; c++)
			@(posedge clk) #1;
		if (c >= lim) begin
			n_errors++;
			end_sim();
		end
	endtask

	task automatic wait_st(input logic [7:0] s);
		int j;
		for (j = 0; j < 3000; j++) begin
			rd(osp_pkg::A_STATE, rv);
			if (rv === s)
				break;
		end
		if (j == 3000) begin
			n_errors++;
			end_sim();
		end
	endtask

	task automatic pgv(input int v, input logic exp);
		mon.vout <= 10'(v);
		repeat (4) @(posedge clk);
		#1 check(16'({pok_oe, pok_o}), 16'({exp, 1'b0}));
	endtask

	// overcurrent drags the output under the undervoltage level
	task automatic trip();
		follow = 1'b0;
		mon.vout <= 10'h000;
		mon.iout <= 8'hff;
		wait_sw(1'b0, 4, n);
		mon.iout <= 8'h00;
		follow = 1'b1;
	endtask

	// load: output follows the reference one cycle late
	always @(posedge clk)
		if (follow)
			mon.vout <= {1'b0, ref_out};

	always @(posedge clk) begin
		prev_ref <= ref_out;
		if (step_on && ref_out !== prev_ref)
			check(16'(ref_out - prev_ref == 9'h001 || prev_ref - ref_out == 9'h001), 16'h1);
	end

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		bus = '0;
		mon = '{vout: 10'h000, iout: 8'h00, temp: osp_pkg::ROOM_C};
		ext_low = 1'b0;
		follow = 1'b1;
		step_on = 1'b0;
		seed = 32'h23e56785;
		n_errors = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(osp_pkg::A_SP, rv);
		check(16'(rv), 16'(osp_pkg::R_SP));
		rd(osp_pkg::A_STAT, rv);
		// power-good warning already stands while the output is off
		check(16'(rv), 16'(osp_pkg::R_STAT & ~(6'h1 << osp_pkg::ST_PG)));
		rd(4'hd, rv);
		check(16'(rv), 16'h0);
		wr(osp_pkg::A_REF, 8'hff);
		rd(osp_pkg::A_REF, rv);
		check(16'(rv), 16'h0);
		// temperature warning while off, so the trip at the same level stays out
		wr(osp_pkg::A_REP, 8'h01);
		mon.temp <= 8'd121;
		repeat (3) @(posedge clk);
		stat(osp_pkg::ST_PT, 1'b0);
		check(16'(warn), 16'h1);
		mon.temp <= 8'd118;
		repeat (3) @(posedge clk);
		stat(osp_pkg::ST_PT, 1'b0);
		mon.temp <= 8'd116;
		repeat (3) @(posedge clk);
		stat(osp_pkg::ST_PT, 1'b1);
		check(16'(warn), 16'h0);
		wr(osp_pkg::A_CLS, 8'h34);
		wr(osp_pkg::A_TON, 8'h02);
		wr(osp_pkg::A_RISE, 8'h02);
		wr(osp_pkg::A_SP, 8'h00);
		step_on = 1'b1;
		wr(osp_pkg::A_RUN, 8'h01);
		wait_sw(1'b1, 100, n);
		check(16'(n), 16'(2 + 2 * DLY));
		for (n = 0; n < 400 && ref_out !== 9'd40; n++)
			@(posedge clk) #1;
		check(16'(n >= 152 && n <= 164), 16'h1);
		foreach (codes[k]) begin
			wr(osp_pkg::A_SP, 8'(codes[k]));
			rd(osp_pkg::A_STATE, rv);
			check(16'(pok_oe), 16'h1);
			wait_st(STDY);
			check(16'(ref_out), 16'(sp_steps(codes[k])));
			repeat (3) @(posedge clk);
			#1 check(16'(pok_oe), 16'h0);
		end
		for (k = 0; k < 8; k++) begin
			seed = xs(seed);
			mon.iout <= {2'b00, seed[5:0]};
			repeat (3) @(posedge clk);
			#1 check(16'(vref_out), 16'(80 - seed[5:0] * 4 / 16));
		end
		mon.iout <= 8'h00;
		wr(osp_pkg::A_REP, 8'h02);
		follow = 1'b0;
		pgv(89, 1'b1);
		stat(osp_pkg::ST_PG, 1'b0);
		check(16'({warn, sw_en}), 16'h3);
		pgv(74, 1'b0);
		wr(osp_pkg::A_THR, 8'h06);
		pgv(74, 1'b1);
		wr(osp_pkg::A_THR, 8'h02);
		pgv(89, 1'b1);
		wr(osp_pkg::A_SP, 8'd48);
		wait_st(STDY);
		pgv(89, 1'b0);
		stat(osp_pkg::ST_PG, 1'b1);
		ext_low = 1'b1;
		repeat (3) @(posedge clk);
		stat(osp_pkg::ST_PG, 1'b0);
		ext_low = 1'b0;
		follow = 1'b1;
		step_on = 1'b0;
		wr(osp_pkg::A_FALL, 8'h00);
		wr(osp_pkg::A_TOFF, 8'h03);
		wr(osp_pkg::A_RUN, 8'h00);
		wait_sw(1'b0, 100, n);
		check(16'(n >= 3 * DLY && n <= 3 * DLY + 3), 16'h1);
		wr(osp_pkg::A_RUN, 8'h01);
		wait_st(STDY);
		wr(osp_pkg::A_FALL, 8'h01);
		wr(osp_pkg::A_TOFF, 8'h3c);
		wr(osp_pkg::A_RUN, 8'h00);
		wait_sw(1'b0, 400, n);
		check(16'(n >= 236 && n <= 248), 16'h1);
		check(16'(ref_out), 16'h0);
		rd(osp_pkg::A_STATE, rv);
		check(16'(rv), 16'(osp_pkg::S_OFF));
		wr(osp_pkg::A_RUN, 8'h01);
		wait_st(STDY);
		trip();
		stat(osp_pkg::ST_OC, 1'b0);
		wait_sw(1'b1, RETRY + 40, n);
		check(16'(n + 2 >= RETRY), 16'h1);
		wait_st(STDY);
		wr(osp_pkg::A_FTYPE, 8'h01);
		trip();
		repeat (2 * RETRY) @(posedge clk);
		#1 check(16'(sw_en), 16'h0);
		wr(osp_pkg::A_STAT, 8'h3f);
		wait_sw(1'b1, 40, n);
		// 85 sits one below 4*16 plus compensation at 116 C, so only undervoltage trips
		wait_st(STDY);
		follow = 1'b0;
		mon.vout <= 10'h000;
		mon.iout <= 8'd85;
		wait_sw(1'b0, 400, n);
		check(16'(n >= 236 && n <= 248), 16'h1);
		stat(osp_pkg::ST_UV, 1'b0);
		stat(osp_pkg::ST_OC, 1'b1);
		end_sim();
	end
endmodule
